// [hw/port_e_pin_function_select.sv]
`timescale 1ns/1ps
`include "port_e_consts.svh"
module port_e_pin_function_select (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic debug_mode_pin_i,
  input wire logic pin14_in_i,
  output logic pin14_out_o,
  output logic pin14_oe_o,
  input wire logic pin13_in_i,
  output logic pin13_out_o,
  output logic pin13_oe_o,
  input wire logic pin12_in_i,
  output logic pin12_out_o,
  output logic pin12_oe_o,
  input wire logic [2:0] port_out_i,
  input wire logic [2:0] port_oe_i,
  output logic [2:0] port_in_o,
  input wire logic timer_chan_c_io_out_i,
  input wire logic timer_chan_c_io_oe_i,
  output logic timer_chan_c_io_in_o,
  input wire logic timer_chan_b_io_out_i,
  input wire logic timer_chan_b_io_oe_i,
  output logic timer_chan_b_io_in_o,
  input wire logic timer_chan_a_io_out_i,
  input wire logic timer_chan_a_io_oe_i,
  output logic timer_chan_a_io_in_o,
  input wire logic dma_ack_0_out_i,
  output logic manual_reset_in_o,
  output logic debug_tck_o
);
  import port_e_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [15:0] ctrl_reg;
  logic [31:0] prdata_reg;

  // True when a field holds the given select code
  function automatic logic sel_is(input func_sel_t field, input func_sel_t code);
    sel_is = (field == code);
  endfunction

  // Address decode and phase qualifiers
  wire addr_hit = (paddr_i == `CTRL1_OFFSET);
  wire setup_ph = psel_i && !penable_i;
  wire access_ph = psel_i && penable_i;
  wire wr_hit = access_ph && pwrite_i && addr_hit;
  wire [15:0] strb_mask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  wire [15:0] wr_mask = strb_mask & `CTRL1_WMASK;
  wire [15:0] ctrl_next = (ctrl_reg & ~wr_mask) | (pwdata_i[15:0] & wr_mask);
  wire [31:0] rd_next = addr_hit ? {16'h0000, ctrl_reg} : 32'h0000_0000;

  // Zero-wait answer, error on unmapped address
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph && !addr_hit;
  assign prdata_o = prdata_reg;

  // Control register, only the three select fields are stored
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= `CTRL1_RESET;
    end else if (wr_hit) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_reg <= rd_next;
    end
  end

  // Field views
  wire func_sel_t sel14 = func_sel_t'(ctrl_reg[`PIN14_SEL_LSB +: 2]);
  wire func_sel_t sel13 = func_sel_t'(ctrl_reg[`PIN13_SEL_LSB +: 2]);
  wire func_sel_t sel12 = func_sel_t'(ctrl_reg[`PIN12_SEL_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers, bit 3 is the debug mode pin

  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;

  // Two flops before any logic looks at a pin
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {debug_mode_pin_i, pin14_in_i, pin13_in_i, pin12_in_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire in14 = pin_sync_reg[2];
  wire in13 = pin_sync_reg[1];
  wire in12 = pin_sync_reg[0];
  wire dbg_mode = pin_sync_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // Function multiplexers, prohibited codes fall back to port I/O

  // Pin 14: port, timer C, DMA acknowledge
  wire c14_tmr = sel_is(sel14, FSEL_ALT1);
  wire c14_dma = sel_is(sel14, FSEL_ALT2);
  wire out14_next = c14_tmr ? timer_chan_c_io_out_i :
                    c14_dma ? dma_ack_0_out_i : port_out_i[2];
  wire oe14_next = c14_tmr ? timer_chan_c_io_oe_i :
                   c14_dma ? 1'b1 : port_oe_i[2];
  wire port14_en = !c14_tmr && !c14_dma;

  // Pin 13: port, timer B, manual reset input
  wire c13_tmr = sel_is(sel13, FSEL_ALT1);
  wire c13_rstin = sel_is(sel13, FSEL_ALT2);
  wire out13_next = c13_tmr ? timer_chan_b_io_out_i :
                    c13_rstin ? 1'b0 : port_out_i[1];
  wire oe13_next = c13_tmr ? timer_chan_b_io_oe_i :
                   c13_rstin ? 1'b0 : port_oe_i[1];
  wire port13_en = !c13_tmr && !c13_rstin;

  // Pin 12: port, timer A, overridden by debug mode
  wire c12_tmr = !dbg_mode && sel_is(sel12, FSEL_ALT1);
  wire port12_en = !dbg_mode && !c12_tmr;
  wire out12_next = c12_tmr ? timer_chan_a_io_out_i :
                    port12_en ? port_out_i[0] : 1'b0;
  wire oe12_next = c12_tmr ? timer_chan_a_io_oe_i :
                   port12_en ? port_oe_i[0] : 1'b0;

  // Inputs handed to whoever owns each pin
  wire [2:0] port_in_next = {port14_en & in14, port13_en & in13, port12_en & in12};
  wire rstin_next = c13_rstin ? in13 : `RSTIN_IDLE;
  wire tck_next = dbg_mode & in12;

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin and peripheral outputs

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin14_out_o <= 1'b0;
      pin14_oe_o <= 1'b0;
      pin13_out_o <= 1'b0;
      pin13_oe_o <= 1'b0;
      pin12_out_o <= 1'b0;
      pin12_oe_o <= 1'b0;
    end else begin
      pin14_out_o <= out14_next;
      pin14_oe_o <= oe14_next;
      pin13_out_o <= out13_next;
      pin13_oe_o <= oe13_next;
      pin12_out_o <= out12_next;
      pin12_oe_o <= oe12_next;
    end
  end

  // Input delivery to port logic and peripherals
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_in_o <= 3'h0;
      timer_chan_c_io_in_o <= 1'b0;
      timer_chan_b_io_in_o <= 1'b0;
      timer_chan_a_io_in_o <= 1'b0;
      manual_reset_in_o <= `RSTIN_IDLE;
      debug_tck_o <= 1'b0;
    end else begin
      port_in_o <= port_in_next;
      timer_chan_c_io_in_o <= c14_tmr & in14;
      timer_chan_b_io_in_o <= c13_tmr & in13;
      timer_chan_a_io_in_o <= c12_tmr & in12;
      manual_reset_in_o <= rstin_next;
      debug_tck_o <= tck_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // Bus write phase with the select lane enabled
  sequence ctrl_write_s;
    psel_i && penable_i && pwrite_i && addr_hit && pstrb_i[1];
  endsequence

  // Read setup followed by its access phase
  sequence ctrl_read_s;
    psel_i && !penable_i && !pwrite_i && addr_hit ##1 psel_i && penable_i;
  endsequence

  // Pin 12 released to the debugger
  sequence dbg_owned_s;
    !pin12_oe_o && !pin12_out_o && !timer_chan_a_io_in_o && !port_in_o[0];
  endsequence

  // Stored fields follow the written word
  sel_write_a: assert property (ctrl_write_s |=>
    ctrl_reg[13:8] == $past(pwdata_i[13:8]) && ctrl_reg[15:14] == 2'b00
    && ctrl_reg[7:0] == 8'h00)
    else $error("select fields not stored as written");

  // Register only moves on a mapped write
  ctrl_hold_a: assert property (
    !(psel_i && penable_i && pwrite_i && addr_hit) |=> $stable(ctrl_reg))
    else $error("control register changed without a write");

  // Every access ends at once, unmapped ones flag an error
  bus_error_a: assert property (psel_i && penable_i |->
    pready_o && pslverr_o == !addr_hit)
    else $error("bus response wrong for address");

  // Read data shows the register as it stood at setup
  sel_read_a: assert property (ctrl_read_s |->
    prdata_o == {16'h0000, $past(ctrl_reg)})
    else $error("read data does not show control register");

  // Reserved bits of the read word stay zero
  reserved_read_a: assert property (prdata_o[31:14] == 18'h0_0000 && prdata_o[7:0] == 8'h00)
    else $error("reserved read bits not zero");

  // Pin 14 in port mode
  pin14_port_a: assert property (sel14 == FSEL_PORT |=>
    pin14_out_o == $past(port_out_i[2]) && pin14_oe_o == $past(port_oe_i[2])
    && port_in_o[2] == $past(in14) && !timer_chan_c_io_in_o)
    else $error("pin 14 port path broken");

  // Pin 14 handed to the DMA acknowledge
  pin14_map_a: assert property (sel14 == FSEL_ALT2 |=>
    pin14_oe_o && pin14_out_o == $past(dma_ack_0_out_i))
    else $error("pin 14 not driven by DMA acknowledge");

  // Pin 14 handed to timer channel C
  pin14_timer_a: assert property (sel14 == FSEL_ALT1 |=>
    pin14_oe_o == $past(timer_chan_c_io_oe_i) && timer_chan_c_io_in_o == $past(in14)
    && pin14_out_o == $past(timer_chan_c_io_out_i))
    else $error("pin 14 timer path broken");

  // Pin 13 in port mode
  pin13_port_a: assert property (sel13 == FSEL_PORT |=>
    pin13_oe_o == $past(port_oe_i[1]) && port_in_o[1] == $past(in13)
    && pin13_out_o == $past(port_out_i[1]) && manual_reset_in_o == `RSTIN_IDLE)
    else $error("pin 13 port path broken");

  // Pin 13 handed to timer channel B
  pin13_timer_a: assert property (sel13 == FSEL_ALT1 |=>
    pin13_out_o == $past(timer_chan_b_io_out_i) && pin13_oe_o == $past(timer_chan_b_io_oe_i)
    && timer_chan_b_io_in_o == $past(in13) && manual_reset_in_o == `RSTIN_IDLE)
    else $error("pin 13 timer path broken");

  // Pin 13 feeding the manual reset input
  pin13_rstin_a: assert property (sel13 == FSEL_ALT2 |=>
    !pin13_oe_o && manual_reset_in_o == $past(in13) && port_in_o[1] == 1'b0)
    else $error("pin 13 manual reset path broken");

  // Timer B sees a quiet input while it does not own pin 13
  timer_b_idle_a: assert property (sel13 != FSEL_ALT1 |=> !timer_chan_b_io_in_o)
    else $error("timer B input not quiet");

  // Pin 12 in port mode
  pin12_port_a: assert property (!dbg_mode && sel12 == FSEL_PORT |=>
    pin12_out_o == $past(port_out_i[0]) && pin12_oe_o == $past(port_oe_i[0])
    && port_in_o[0] == $past(in12) && !debug_tck_o)
    else $error("pin 12 port path broken");

  // Pin 12 handed to timer channel A
  pin12_timer_a: assert property (!dbg_mode && sel12 == FSEL_ALT1 |=>
    pin12_out_o == $past(timer_chan_a_io_out_i) && timer_chan_a_io_in_o == $past(in12)
    && pin12_oe_o == $past(timer_chan_a_io_oe_i))
    else $error("pin 12 timer path broken");

  // Timer A sees a quiet input while it does not own pin 12
  timer_a_idle_a: assert property (dbg_mode || sel12 != FSEL_ALT1 |=>
    !timer_chan_a_io_in_o)
    else $error("timer A input not quiet");

  // Debug level reaches the override after two stages
  sync_delay_a: assert property ($changed(dbg_mode) |->
    dbg_mode == $past(debug_mode_pin_i, 2))
    else $error("debug level not synchronised in two stages");

  // Debug mode owns pin 12 whatever its field holds
  debug_force_a: assert property (dbg_mode |=>
    dbg_owned_s ##0 debug_tck_o == $past(in12))
    else $error("debug mode does not own pin 12");

endmodule

// [common/port_e_consts.svh]
`ifndef PORT_E_CONSTS_SVH
`define PORT_E_CONSTS_SVH

// Register map
`define CTRL1_OFFSET 32'h0000_0000
`define CTRL1_RESET 16'h0000
`define CTRL1_WMASK 16'h3F00

// Field positions inside the control register
`define PIN14_SEL_LSB 12
`define PIN13_SEL_LSB 10
`define PIN12_SEL_LSB 8

// Function select codes
`define SEL_PORT 2'h0
`define SEL_ALT1 2'h1
`define SEL_ALT2 2'h2

// Level on the manual reset line while pin 13 is not routed to it
`define RSTIN_IDLE 1'h1

`endif

// [common/port_e_pkg.sv]
package port_e_pkg;

  // Two-bit pin function select, code 2'b11 is prohibited but is still stored if written
  typedef enum logic [1:0] {
    FSEL_PORT = 2'b00,
    FSEL_ALT1 = 2'b01,
    FSEL_ALT2 = 2'b10,
    FSEL_BAD  = 2'b11
  } func_sel_t;

endpackage

// [verif/tb_top.sv]
`timescale 1ns/1ps
`include "port_e_consts.svh"
module tb_top;
  logic clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, dbg = 0, er;
  logic [31:0] paddr_i = '0, pwdata_i = '0, rd, prdata_o;
  logic [3:0] pstrb_i = '0;
  logic [2:0] pin_in = 3'b101, pout = '0, poe = '0, port_in;
  logic tco = 1, tce = 1, tbo = 1, tbe = 1, tao = 1, tae = 1, dma = 1;
  logic pready_o, pslverr_o, p14o, p14e, p13o, p13e, p12o, p12e, tci, tbi, tai, mri, tck;
  logic [5:0] exp_p [3] = '{6'h00, 6'h3F, 6'h30};
  logic [6:0] exp_i [3] = '{7'b101_0001, 7'b000_1011, 7'b001_0000};
  logic [31:0] ctrl;
  int err_total = 0, checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Device under test
  port_e_pin_function_select u_port_e_pin_function_select (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .debug_mode_pin_i(dbg), .pin14_in_i(pin_in[2]),
    .pin14_out_o(p14o), .pin14_oe_o(p14e), .pin13_in_i(pin_in[1]), .pin13_out_o(p13o),
    .pin13_oe_o(p13e), .pin12_in_i(pin_in[0]), .pin12_out_o(p12o), .pin12_oe_o(p12e),
    .port_out_i(pout), .port_oe_i(poe), .port_in_o(port_in), .timer_chan_c_io_out_i(tco),
    .timer_chan_c_io_oe_i(tce), .timer_chan_c_io_in_o(tci), .timer_chan_b_io_out_i(tbo),
    .timer_chan_b_io_oe_i(tbe), .timer_chan_b_io_in_o(tbi), .timer_chan_a_io_out_i(tao),
    .timer_chan_a_io_oe_i(tae), .timer_chan_a_io_in_o(tai), .dma_ack_0_out_i(dma),
    .manual_reset_in_o(mri), .debug_tck_o(tck));
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= wr ? 4'hF : 4'h0;
    @(posedge clk_i);
    penable_i <= 1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    if (pready_o !== 1'b1) begin
      err_total++;
      $display("Error pready expected 1 seen %b", pready_o);
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    #(25 * 5000);
    err_total++;
    $display("Error run time expected under 5000 cycles seen limit");
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1;
    apb(0, `CTRL1_OFFSET, 32'h0, rd, er);
    chk("ctrl reset", 32'h0, rd);
    chk("mapped error", 32'h0, er);
    apb(1, `CTRL1_OFFSET, 32'hFFFF_2900, rd, er);
    apb(0, `CTRL1_OFFSET, 32'h0, rd, er);
    chk("ctrl fields", 32'h0000_2900, rd);
    $display("test register done");
    // Every legal code on all three pins; pin 12 stays port when others use code 10
    for (int m = 0; m < 3; m++) begin
      ctrl = (m << 12) | (m << 10) | ((m == 2 ? 0 : m) << 8);
      apb(1, `CTRL1_OFFSET, ctrl, rd, er);
      repeat (6) @(posedge clk_i);
      chk("pin drive", exp_p[m], {p14o, p14e, p13o, p13e, p12o, p12e});
      chk("pin sense", exp_i[m], {port_in, tci, tbi, tai, mri});
    end
    $display("test modes done");
    apb(1, 32'h0000_0004, 32'h0, rd, er);
    chk("unmapped error", 32'h1, er);
    apb(0, `CTRL1_OFFSET, 32'h0, rd, er);
    chk("ctrl kept", 32'h0000_2800, rd);
    $display("test unmapped done");
    apb(1, `CTRL1_OFFSET, 32'h0000_0100, rd, er);
    dbg <= 1;
    repeat (6) @(posedge clk_i);
    chk("debug clock", 32'h4, {tck, p12e, tai});
    pin_in[0] <= 0;
    repeat (6) @(posedge clk_i);
    chk("debug clock low", 32'h0, {tck, p12e, tai});
    dbg <= 0;
    pin_in[0] <= 1;
    repeat (6) @(posedge clk_i);
    chk("debug released", 32'h3, {tck, p12e, tai});
    $display("test debug done");
    // Reset in mid-run puts every pin back to port I/O
    apb(1, `CTRL1_OFFSET, 32'h0000_1500, rd, er);
    repeat (6) @(posedge clk_i);
    arst_n_i <= 0;
    repeat (2) @(posedge clk_i);
    chk("reset pins", 32'h2, {port_in, p14o, p14e, p13o, p13e, p12o, p12e, tci, tbi, tai, mri, tck});
    arst_n_i <= 1;
    apb(0, `CTRL1_OFFSET, 32'h0, rd, er);
    chk("ctrl after reset", 32'h0, rd);
    $display("test reset done");
    end_of_test();
  end
endmodule
